// >>> hw/spfc_ctrl.sv
// Self-programming flash control: command register, arming window, page buffer, lock bits
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

module spfc_ctrl
  import spfc_pkg::*;
(
  input  wire  logic        core_clk,
  input  wire  logic        resetn,
  // Avalon-MM register slave
  input  wire  logic [3:0]  avs_address,
  input  wire  logic        avs_read,
  input  wire  logic        avs_write,
  input  wire  logic [31:0] avs_writedata,
  input  wire  logic [3:0]  avs_byteenable,
  output logic       [31:0] avs_readdata,
  output logic              avs_waitrequest,
  // Core store/load instruction port
  input  wire  logic        store_req,
  input  wire  logic        load_req,
  input  wire  logic [15:0] z_pointer,
  input  wire  logic [15:0] store_data,
  input  wire  logic        exec_in_boot,
  input  wire  logic        vectors_in_boot,
  input  wire  logic        global_irq_en,
  output logic              store_done,
  output logic              load_valid,
  output logic       [7:0]  load_data,
  output logic              load_blocked,
  output logic              core_stall,
  output logic              store_ready_irq,
  output logic              irq_disable,
  // Flash array side
  input  wire  logic [7:0]  flash_rdata,
  input  wire  logic [7:0]  fuse_byte,
  input  wire  logic        flash_done,
  input  wire  logic        chip_erase,
  input  wire  logic [5:0]  buf_rd_index,
  output logic       [15:0] buf_rd_data,
  output logic              flash_erase_start,
  output logic              flash_write_start,
  output logic       [6:0]  flash_page,
  // Lock status for external programming
  output logic              ext_prog_allowed,
  output logic              ext_verify_allowed,
  output logic              fuse_locked,
  output logic              boot_lock_locked
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  spfc_state_type state_reg;
  spfc_state_type state_next;
  logic [2:0]  win_cnt_reg;
  logic [2:0]  win_cnt_next;
  logic [4:0]  cmd_reg;
  logic [4:0]  cmd_next;
  logic        ie_reg;
  logic        busy_reg;
  logic        busy_next;
  logic        stall_reg;
  logic        stall_next;
  logic        loading_reg;
  logic        loading_next;
  logic [7:0]  lock_reg;
  logic [7:0]  lock_next;
  logic [6:0]  page_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [SPFC_WORDS-1:0] valid_reg;
  logic [15:0] page_buf [SPFC_WORDS];
  logic [15:0] buf_rd_reg;
  logic        store_done_reg;
  logic        load_valid_reg;
  logic [7:0]  load_data_reg;
  logic        load_blocked_reg;
  logic        erase_start_reg;
  logic        write_start_reg;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire         bus_req    = avs_read | avs_write;
  wire         bus_take   = bus_req & ack_reg;
  wire         sel_ctrl   = avs_address == SPFC_OFF_CTRL;
  wire         sel_lock   = avs_address == SPFC_OFF_LOCK;
  wire         ctrl_wr    = avs_write & bus_take & sel_ctrl & avs_byteenable[0];
  wire  [4:0]  wr_cmd     = avs_writedata[4:0];
  wire         cmd_legal  = (wr_cmd == SPFC_CMD_REEN) | (wr_cmd == SPFC_CMD_LOCK) |
                            (wr_cmd == SPFC_CMD_PGWR) | (wr_cmd == SPFC_CMD_PGER) |
                            (wr_cmd == SPFC_CMD_FILL);
  wire         cmd_accept = ctrl_wr & cmd_legal & (state_reg == SPFC_IDLE);
  wire         enable_bit = cmd_reg[SPFC_BIT_EN];
  wire         armed      = state_reg == SPFC_ARMED;
  wire         store_go   = armed & store_req;
  wire         win_last   = win_cnt_reg == SPFC_STORE_WIN - 3'h1;
  wire  [12:0] z_word     = z_pointer[13:1];
  wire  [12:0] ld_word    = z_pointer[13:1];
  wire  [5:0]  z_index    = z_pointer[6:1];
  wire         tgt_no_concurrent_read_section   = z_word >= SPFC_NO_CONCURRENT_READ_SECTION_START;
  wire         tgt_boot   = z_word >= SPFC_BOOT_START;
  wire         ld_boot    = ld_word >= SPFC_BOOT_START;
  wire         ld_rww     = ld_word < SPFC_NO_CONCURRENT_READ_SECTION_START;
  wire         app_wr_deny  = ~lock_reg[SPFC_BIT_APP_LO];
  wire         boot_wr_deny = ~lock_reg[SPFC_BIT_BOOT_LO];
  wire         store_deny   = tgt_boot ? boot_wr_deny : app_wr_deny;
  wire         app_rd_deny  = ~lock_reg[SPFC_BIT_APP_HI];
  wire         boot_rd_deny = ~lock_reg[SPFC_BIT_BOOT_HI];
  wire         cmd_fill   = cmd_reg == SPFC_CMD_FILL;
  wire         cmd_reen   = cmd_reg == SPFC_CMD_REEN;
  wire         cmd_lock   = cmd_reg == SPFC_CMD_LOCK;
  wire         cmd_page   = (cmd_reg == SPFC_CMD_PGWR) | (cmd_reg == SPFC_CMD_PGER);
  wire         page_go    = store_go & cmd_page & ~store_deny;
  wire         fill_go    = store_go & cmd_fill;
  wire         lock_go    = store_go & cmd_lock;
  wire         lock_window = armed & cmd_lock & (win_cnt_reg < SPFC_LOAD_WIN);
  wire         ld_sec_deny = exec_in_boot ? (~ld_boot & app_rd_deny) :
                                            (ld_boot & boot_rd_deny);
  wire         ld_busy_deny = busy_reg & ld_rww;
  wire  [7:0]  ld_special = z_pointer[0] ? fuse_byte : lock_reg;
  wire  [7:0]  ctrl_view  = {ie_reg, busy_reg, 1'b0, cmd_reg};
  wire  [7:0]  lock_wr_val = lock_reg & ~(SPFC_LOCK_WMASK & ~store_data[7:0]);
  wire         gen_mode3  = ~lock_reg[SPFC_BIT_GEN_HI] & ~lock_reg[SPFC_BIT_GEN_LO];

  // Read data selection; unmapped addresses read zero
  wire  [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_view} :
                        sel_lock ? {24'h000000, lock_reg}  : 32'h00000000;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------

  // Next state of arming window, command bits, busy flag, stall and lock bits
  always_comb begin
    state_next   = state_reg;
    win_cnt_next = win_cnt_reg;
    cmd_next     = cmd_reg;
    busy_next    = busy_reg;
    stall_next   = stall_reg;
    loading_next = loading_reg;
    lock_next    = lock_reg;
    case (state_reg)
      SPFC_IDLE: begin
        if (cmd_accept) begin
          cmd_next     = wr_cmd;
          win_cnt_next = 3'h0;
          state_next   = SPFC_ARMED;
          if (wr_cmd == SPFC_CMD_REEN) begin
            loading_next = 1'b0;
          end
        end
      end
      SPFC_ARMED: begin
        if (store_go) begin
          if (page_go) begin
            state_next = SPFC_PAGE_BUSY;
            busy_next  = ~tgt_no_concurrent_read_section | busy_reg;
            stall_next = tgt_no_concurrent_read_section;
            if (cmd_reg == SPFC_CMD_PGWR) begin
              loading_next = 1'b0;
            end
          end else begin
            state_next = SPFC_IDLE;
            cmd_next   = 5'h00;
            if (cmd_fill) begin
              busy_next    = 1'b0;
              loading_next = 1'b1;
            end
            if (cmd_reen) begin
              busy_next = 1'b0;
            end
            if (lock_go) begin
              lock_next = lock_wr_val;
            end
          end
        end else if (win_last) begin
          state_next = SPFC_IDLE;
          cmd_next   = 5'h00;
        end else begin
          win_cnt_next = win_cnt_reg + 3'h1;
        end
      end
      SPFC_PAGE_BUSY: begin
        if (flash_done) begin
          state_next = SPFC_IDLE;
          cmd_next   = 5'h00;
          stall_next = 1'b0;
        end
      end
      default: begin
        state_next = SPFC_IDLE;
        cmd_next   = 5'h00;
      end
    endcase
    if (chip_erase) begin
      lock_next = SPFC_LOCK_RESET;
    end
  end

  // Sequencer registers
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg   <= SPFC_IDLE;
      win_cnt_reg <= 3'h0;
      cmd_reg     <= 5'h00;
      busy_reg    <= 1'b0;
      stall_reg   <= 1'b0;
      loading_reg <= 1'b0;
      lock_reg    <= SPFC_LOCK_RESET;
      page_reg    <= 7'h00;
    end else begin
      state_reg   <= state_next;
      win_cnt_reg <= win_cnt_next;
      cmd_reg     <= cmd_next;
      busy_reg    <= busy_next;
      stall_reg   <= stall_next;
      loading_reg <= loading_next;
      lock_reg    <= lock_next;
      if (page_go) begin
        page_reg <= z_pointer[13:7];
      end
    end
  end

  // Interrupt enable bit, writable at any time
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ie_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ie_reg <= avs_writedata[SPFC_BIT_IE];
    end
  end

  // ---------------------------------------------------------------
  // Temporary page buffer
  // ---------------------------------------------------------------

  // Valid flags: set on fill, dropped on abort or when the page write completes (flash_done)
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      valid_reg <= '0;
    end else if (cmd_accept & (wr_cmd == SPFC_CMD_REEN) & loading_reg) begin
      valid_reg <= '0;
    end else if (flash_done & (cmd_reg == SPFC_CMD_PGWR)) begin
      valid_reg <= '0;
    end else if (fill_go) begin
      valid_reg[z_index] <= 1'b1;
    end
  end

  // Buffer words, one generate entry each
  for (genvar i = 0; i < SPFC_WORDS; i++) begin : g_buf
    always_ff @(posedge core_clk) begin
      if (fill_go && (z_index == 6'(i))) begin
        page_buf[i] <= store_data;
      end
    end
  end

  // Registered buffer read port toward the flash array
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      buf_rd_reg <= SPFC_BLANK_WORD;
    end else begin
      buf_rd_reg <= valid_reg[buf_rd_index] ? page_buf[buf_rd_index] : SPFC_BLANK_WORD;
    end
  end

  // ---------------------------------------------------------------
  // Core answers and flash strobes
  // ---------------------------------------------------------------

  // One-cycle answers to store and load instructions
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      store_done_reg   <= 1'b0;
      load_valid_reg   <= 1'b0;
      load_data_reg    <= 8'h00;
      load_blocked_reg <= 1'b0;
      erase_start_reg  <= 1'b0;
      write_start_reg  <= 1'b0;
    end else begin
      store_done_reg   <= (store_go & ~page_go) | (flash_done & (state_reg == SPFC_PAGE_BUSY));
      load_valid_reg   <= load_req;
      load_blocked_reg <= load_req & ~lock_window & (ld_sec_deny | ld_busy_deny);
      erase_start_reg  <= page_go & (cmd_reg == SPFC_CMD_PGER);
      write_start_reg  <= page_go & (cmd_reg == SPFC_CMD_PGWR);
      if (load_req) begin
        if (lock_window) begin
          load_data_reg <= ld_special;
        end else if (ld_sec_deny | ld_busy_deny) begin
          load_data_reg <= SPFC_DENY_BYTE;
        end else begin
          load_data_reg <= flash_rdata;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------

  // One wait cycle per access, then the answer edge
  always_ff @(posedge core_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read & ~ack_reg) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_waitrequest    = bus_req & ~ack_reg;
  assign avs_readdata       = rdata_reg;
  assign store_done         = store_done_reg;
  assign load_valid         = load_valid_reg;
  assign load_data          = load_data_reg;
  assign load_blocked       = load_blocked_reg;
  assign core_stall         = stall_reg;
  assign store_ready_irq    = ie_reg & global_irq_en & ~enable_bit;
  assign irq_disable        = vectors_in_boot ? (~exec_in_boot & app_rd_deny) :
                                                (exec_in_boot & boot_rd_deny);
  assign buf_rd_data        = buf_rd_reg;
  assign flash_erase_start  = erase_start_reg;
  assign flash_write_start  = write_start_reg;
  assign flash_page         = page_reg;
  assign ext_prog_allowed   = lock_reg[SPFC_BIT_GEN_LO];
  assign ext_verify_allowed = ~gen_mode3;
  assign fuse_locked        = ~lock_reg[SPFC_BIT_GEN_LO];
  assign boot_lock_locked   = gen_mode3;

endmodule

// >>> inc/spfc_pkg.sv
// Package of offsets, field positions, reset values and timing counts for the flash sequencer
package spfc_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, one aligned word each)
  // ---------------------------------------------------------------
  localparam logic [3:0] SPFC_OFF_CTRL = 4'h0;  // self_program_control_status
  localparam logic [3:0] SPFC_OFF_LOCK = 4'h4;  // lock_bit_byte, read only

  // ---------------------------------------------------------------
  // Control/status field positions
  // ---------------------------------------------------------------
  localparam int SPFC_BIT_IE     = 7;  // store_ready_irq_enable
  localparam int SPFC_BIT_BUSY   = 6;  // section_busy_flag
  localparam int SPFC_BIT_RSVD   = 5;  // reads zero
  localparam int SPFC_BIT_REEN   = 4;  // section_reenable_bit
  localparam int SPFC_BIT_LOCK   = 3;  // lock_set_bit
  localparam int SPFC_BIT_PGWR   = 2;  // page_write_bit
  localparam int SPFC_BIT_PGER   = 1;  // page_erase_bit
  localparam int SPFC_BIT_EN     = 0;  // store_enable_bit

  // Accepted low-five-bit command patterns
  localparam logic [4:0] SPFC_CMD_REEN = 5'h11;
  localparam logic [4:0] SPFC_CMD_LOCK = 5'h09;
  localparam logic [4:0] SPFC_CMD_PGWR = 5'h05;
  localparam logic [4:0] SPFC_CMD_PGER = 5'h03;
  localparam logic [4:0] SPFC_CMD_FILL = 5'h01;

  // ---------------------------------------------------------------
  // Lock byte layout and reset value
  // ---------------------------------------------------------------
  localparam logic [7:0] SPFC_LOCK_RESET = 8'hff;  // All unprogrammed
  localparam logic [7:0] SPFC_LOCK_WMASK = 8'h3f;  // Six lock bits
  localparam int SPFC_BIT_BOOT_HI = 5;
  localparam int SPFC_BIT_BOOT_LO = 4;
  localparam int SPFC_BIT_APP_HI  = 3;
  localparam int SPFC_BIT_APP_LO  = 2;
  localparam int SPFC_BIT_GEN_HI  = 1;
  localparam int SPFC_BIT_GEN_LO  = 0;

  // ---------------------------------------------------------------
  // Flash geometry (word addresses, pointer bit fields)
  // ---------------------------------------------------------------
  localparam int          SPFC_WORD_W     = 6;        // Words per page index width
  localparam int          SPFC_PAGE_W     = 7;        // Page index width
  localparam int          SPFC_WORDS      = 64;       // Words in a page
  localparam logic [12:0] SPFC_NO_CONCURRENT_READ_SECTION_START = 13'h1c00; // First word of no-concurrent-read area
  localparam logic [12:0] SPFC_BOOT_START = 13'h1c00; // First word of boot section
  localparam logic [15:0] SPFC_BLANK_WORD = 16'hffff; // Discarded or unloaded buffer word
  localparam logic [7:0]  SPFC_DENY_BYTE  = 8'hff;    // Load answer when read is refused

  // ---------------------------------------------------------------
  // Timing counts in core_clk cycles
  // ---------------------------------------------------------------
  localparam logic [2:0] SPFC_STORE_WIN = 3'h4;  // Store window
  localparam logic [2:0] SPFC_LOAD_WIN  = 3'h3;  // Lock/fuse load window

  typedef enum {SPFC_IDLE, SPFC_ARMED, SPFC_PAGE_BUSY} spfc_state_type;

endpackage

// >>> test/spfc_core_model.sv
// Behavioural processor core and flash array facing the sequencer
`timescale 1ns/1ps
module spfc_core_model #(
  parameter int FLASH_LAT = 20
) (
  input  wire logic        core_clk,
  input  wire logic        flash_erase_start,
  input  wire logic        flash_write_start,
  input  wire logic [7:0]  load_data,
  input  wire logic        load_valid,
  output logic             store_req,
  output logic             load_req,
  output logic      [15:0] z_pointer,
  output logic      [15:0] store_data,
  output logic             flash_done
);
  int busy_cnt = 0;

  // Quiet lines at time zero
  initial begin
    store_req = 1'b0;
    load_req = 1'b0;
    z_pointer = 16'h0000;
    store_data = 16'h0000;
    flash_done = 1'b0;
  end

  // Flash array reports a started page operation done after a fixed delay
  always @(posedge core_clk) begin
    flash_done <= (busy_cnt == 1);
    if (flash_erase_start || flash_write_start) busy_cnt <= FLASH_LAT;
    else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
  end

  // One store instruction; released lines show the inverse value
  task automatic store(input logic [15:0] z, input logic [15:0] d);
    @(posedge core_clk);
    z_pointer <= z;
    store_data <= d;
    store_req <= 1'b1;
    @(posedge core_clk);
    store_req <= 1'b0;
    z_pointer <= ~z;
    store_data <= ~d;
  endtask

  // One load instruction; answer taken at the edge where load_valid is sampled
  task automatic load(input logic [15:0] z, output logic [7:0] v);
    @(posedge core_clk);
    z_pointer <= z;
    load_req <= 1'b1;
    @(posedge core_clk);
    load_req <= 1'b0;
    z_pointer <= ~z;
    @(posedge core_clk);
    v = load_valid ? load_data : ~load_data;
  endtask
endmodule

// >>> test/spfc_ctrl_sva.sv
// Checker module for the flash sequencer ports, bound into the block
`timescale 1ns/1ps
module spfc_ctrl_sva
  import spfc_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        load_req,
  input wire logic        load_valid,
  input wire logic        load_blocked,
  input wire logic [7:0]  load_data,
  input wire logic        store_req,
  input wire logic        store_done,
  input wire logic        flash_erase_start,
  input wire logic        flash_write_start,
  input wire logic        flash_done,
  input wire logic [15:0] z_pointer,
  input wire logic        core_stall,
  input wire logic        ext_prog_allowed,
  input wire logic        ext_verify_allowed,
  input wire logic        boot_lock_locked,
  input wire logic        fuse_locked
);
  // Any page start, and the word address the store pointed at
  wire logic        page_start = flash_erase_start | flash_write_start;
  wire logic [12:0] word_addr  = z_pointer[13:1];

  // All checks run on the core clock and rest during reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Load answers, page starts, stalls, completions and lock status outputs
  load_turn_a: assert property (load_req |=> load_valid)
    else $error("load answered late");
  deny_data_a: assert property (load_blocked |-> load_valid && load_data == SPFC_DENY_BYTE)
    else $error("refused load carried data");
  start_cause_a: assert property (page_start |-> $past(store_req))
    else $error("page operation started without a store");
  stall_start_a: assert property (page_start |->
    core_stall == ($past(word_addr) >= SPFC_NO_CONCURRENT_READ_SECTION_START))
    else $error("stall does not match target section");
  stall_hold_a: assert property (core_stall && !flash_done |=> core_stall)
    else $error("stall dropped before flash finished");
  stall_end_a: assert property (core_stall && flash_done |=> !core_stall && store_done)
    else $error("stall or completion wrong after flash finished");
  done_cause_a: assert property (store_done |-> $past(store_req) || $past(flash_done))
    else $error("store completion without cause");
  fuse_lock_a: assert property (!ext_prog_allowed |-> fuse_locked)
    else $error("fuses open while programming is locked");
  lock_mode_a: assert property (boot_lock_locked |-> !ext_prog_allowed && !ext_verify_allowed)
    else $error("mode three left programming open");
endmodule

bind spfc_ctrl spfc_ctrl_sva chk (.*);

// >>> test/spfc_ctrl_tb.sv
// Self-checking bench for the self-programming flash control block
`timescale 1ns/1ps
module spfc_ctrl_tb;
  import spfc_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic        global_irq_en = 1'b0;
  logic        chip_erase = 1'b0;
  logic        exec_in_boot = 1'b0;
  logic        vectors_in_boot = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic [7:0]  flash_rdata = 8'h5a;
  logic [7:0]  fuse_byte = 8'hc3;
  logic [5:0]  buf_rd_index = 6'h00;
  logic [31:0] avs_readdata, q;
  logic [15:0] z_pointer, store_data, buf_rd_data;
  logic [7:0]  load_data, ld0, ld1;
  logic [6:0]  flash_page;
  logic        avs_waitrequest, store_req, load_req, store_done, load_valid, load_blocked;
  logic        core_stall, store_ready_irq, irq_disable, flash_done, flash_erase_start;
  logic        flash_write_start, ext_prog_allowed, ext_verify_allowed;
  logic        fuse_locked, boot_lock_locked;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;

  // Clock at 25 MHz, block under test and the core beside it
  always #20 core_clk = ~core_clk;
  spfc_ctrl uut (.*);
  spfc_core_model #(.FLASH_LAT(20)) core (.*);

  // Compare one value, count it, report a difference
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD %0t saw %h want %h", $time, seen, want);
    end
  endtask

  // One register access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n == 50) mismatches++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // Register read with comparison, and command write
  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h0, want});
  endtask
  task automatic cmd(input logic [4:0] c);
    bus(1'b1, SPFC_OFF_CTRL, {3'h0, c});
  endtask

  // Wait for the store completion pulse under a bound
  task automatic wait_done;
    int n;
    n = 0;
    while (store_done !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    chk(store_done, 32'h1);
  endtask

  // Reset values, refused patterns, window expiry, interrupt level
  task automatic s_regs;
    rd(SPFC_OFF_CTRL, 8'h00);
    rd(SPFC_OFF_LOCK, SPFC_LOCK_RESET);
    bus(1'b1, SPFC_OFF_LOCK, 8'h00);
    bus(1'b1, 4'h8, 8'h01);
    rd(4'h8, 8'h00);
    rd(SPFC_OFF_LOCK, 8'hff);
    bus(1'b1, SPFC_OFF_CTRL, 8'h07);
    rd(SPFC_OFF_CTRL, 8'h00);
    bus(1'b1, SPFC_OFF_CTRL, 8'h21);
    rd(SPFC_OFF_CTRL, 8'h01);
    repeat (4) @(posedge core_clk);
    rd(SPFC_OFF_CTRL, 8'h00);
    global_irq_en <= 1'b1;
    bus(1'b1, SPFC_OFF_CTRL, 8'h80);
    @(negedge core_clk);
    chk(store_ready_irq, 32'h1);
    bus(1'b1, SPFC_OFF_CTRL, 8'h00);
    @(negedge core_clk);
    chk(store_ready_irq, 32'h0);
  endtask

  // Buffer fill, then abort by re-enable
  task automatic s_fill;
    cmd(SPFC_CMD_FILL);
    core.store(16'h0005, 16'ha5c3);
    buf_rd_index <= 6'h02;
    @(negedge core_clk);
    chk(store_done, 32'h1);
    @(negedge core_clk);
    chk(buf_rd_data, 32'ha5c3);
    cmd(SPFC_CMD_REEN);
    core.store(16'h0000, 16'h0000);
    repeat (2) @(negedge core_clk);
    chk(buf_rd_data, {16'h0, SPFC_BLANK_WORD});
  endtask

  // Page write to the concurrent-read section, busy flag and re-enable
  task automatic s_page;
    cmd(SPFC_CMD_PGWR);
    core.store(16'h0180, 16'h1234);
    @(negedge core_clk);
    chk(flash_write_start, 32'h1);
    chk(flash_page, 32'h03);
    cmd(SPFC_CMD_REEN);
    rd(SPFC_OFF_CTRL, 8'h45);
    core.load(16'h0100, ld0);
    chk(ld0, {24'h0, SPFC_DENY_BYTE});
    wait_done();
    rd(SPFC_OFF_CTRL, 8'h40);
    cmd(SPFC_CMD_REEN);
    core.store(16'h0000, 16'h0000);
    core.load(16'h0100, ld0);
    chk(ld0, {24'h0, flash_rdata});
  endtask

  // Erase in the stalling section, then an unused page-write window
  task automatic s_no_concurrent_read_section;
    cmd(SPFC_CMD_PGER);
    core.store(16'h3880, 16'h0000);
    @(negedge core_clk);
    chk(flash_erase_start, 32'h1);
    chk(flash_page, 32'h71);
    chk(core_stall, 32'h1);
    wait_done();
    chk(core_stall, 32'h0);
    cmd(SPFC_CMD_PGWR);
    repeat (5) @(posedge core_clk);
    core.store(16'h0180, 16'h0000);
    @(negedge core_clk);
    chk(flash_write_start, 32'h0);
  endtask

  // Lock and fuse reads, lock programming, section protection, chip erase
  task automatic s_lock;
    cmd(SPFC_CMD_LOCK);
    core.load(16'h0000, ld0);
    repeat (4) @(posedge core_clk);
    cmd(SPFC_CMD_LOCK);
    core.load(16'h0001, ld1);
    chk(ld0 ^ ld1, 32'h3c);
    chk(ld0 & ld1, {24'h0, fuse_byte});
    repeat (4) @(posedge core_clk);
    cmd(SPFC_CMD_LOCK);
    core.store(16'h0000, 16'h00f3);
    rd(SPFC_OFF_LOCK, 8'hf3);
    vectors_in_boot <= 1'b1;
    exec_in_boot <= 1'b1;
    core.load(16'h0100, ld0);
    chk(ld0, {24'h0, SPFC_DENY_BYTE});
    exec_in_boot <= 1'b0;
    @(negedge core_clk);
    chk(irq_disable, 32'h1);
    cmd(SPFC_CMD_PGWR);
    core.store(16'h0180, 16'h0000);
    @(negedge core_clk);
    chk(flash_write_start, 32'h0);
    chk(store_done, 32'h1);
    @(posedge core_clk);
    chip_erase <= 1'b1;
    @(posedge core_clk);
    chip_erase <= 1'b0;
    rd(SPFC_OFF_LOCK, 8'hff);
    chk(irq_disable, 32'h0);
    cmd(SPFC_CMD_LOCK);
    core.store(16'h0000, 16'h00fe);
    @(negedge core_clk);
    chk(ext_prog_allowed, 32'h0);
    chk(fuse_locked, 32'h1);
    chk(ext_verify_allowed, 32'h1);
    chk(boot_lock_locked, 32'h0);
    cmd(SPFC_CMD_LOCK);
    core.store(16'h0000, 16'h00fc);
    @(negedge core_clk);
    chk(ext_verify_allowed, 32'h0);
    chk(boot_lock_locked, 32'h1);
  endtask

  // Counts and verdict, then stop
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Reset, scenarios, verdict
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    s_regs();
    s_fill();
    s_page();
    s_no_concurrent_read_section();
    s_lock();
    give_verdict();
  end

  // Cut a hung run short
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      give_verdict();
    end
  end
endmodule
